// >>> src/sat_pkg.sv
package sat_pkg;

    // ----------------------------------------------------------------
    // Sizes
    // ----------------------------------------------------------------
    localparam int SAT_SETS = 4;
    localparam int SAT_PINS = 8;
    localparam int SAT_CODE_W = 4;
    localparam int SAT_ACT_W = 5;
    localparam int SAT_ACT_TYPES = 24;
    localparam int SAT_TMR_W = 32;
    localparam int SAT_PIN_FILL = 3;

    // ----------------------------------------------------------------
    // Activation factor codes
    // ----------------------------------------------------------------
    localparam logic [3:0] SAT_NO_TRIGGER_CODE = 4'h0;
    localparam logic [3:0] SAT_CODE_CMP_TRUE = 4'h1;
    localparam logic [3:0] SAT_CODE_TIMER_UP = 4'h2;
    localparam logic [3:0] SAT_CODE_DRV_START = 4'h3;
    localparam logic [3:0] SAT_CODE_CONST_START = 4'h4;
    localparam logic [3:0] SAT_CODE_CONST_END = 4'h5;
    localparam logic [3:0] SAT_CODE_DRV_END = 4'h6;
    localparam logic [3:0] SAT_CODE_SPLIT_START = 4'h7;
    localparam logic [3:0] SAT_CODE_SPLIT_END = 4'h8;
    localparam logic [3:0] SAT_CODE_SPLIT_PULSE = 4'h9;
    localparam logic [3:0] SAT_CODE_PIN_RISE = 4'ha;
    localparam logic [3:0] SAT_CODE_PIN_FALL = 4'hb;
    localparam logic [3:0] SAT_CODE_LOW_RISE = 4'hc;
    localparam logic [3:0] SAT_CODE_HIGH_RISE = 4'hd;
    localparam logic [3:0] SAT_CODE_LOW_FALL = 4'he;
    localparam logic [3:0] SAT_CODE_HIGH_FALL = 4'hf;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] SAT_PIN_RST = 8'h00;
    localparam logic [3:0] SAT_SET_RST = 4'h0;
    localparam logic [4:0] SAT_ACT_RST = 5'h00;
    localparam logic [31:0] SAT_TMR_RST = 32'h00000000;
    localparam logic [SAT_PIN_FILL-1:0] SAT_FILL_RST = 3'h0;

    // Timer states
    typedef enum logic [1:0] {
        SAT_TMR_IDLE = 2'b01,
        SAT_TMR_RUN = 2'b10
    } sat_tmr_state_t;

endpackage

// >>> src/sat_timer.sv
`timescale 1ns/1ps
`default_nettype none

module sat_timer
    import sat_pkg::*;
#(
    parameter int TMR_W = SAT_TMR_W
)
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic timerStart,
    input wire logic [TMR_W-1:0] timerValue,
    output logic timerExpired,
    output logic timerRunning
);

    typedef struct packed {
        sat_tmr_state_t state;
        logic [TMR_W-1:0] count;
        logic expired;
    } sat_tmr_t;

    sat_tmr_t st_reg;
    sat_tmr_t st_next;

    // Countdown; a restart while running reloads the count
    always_comb
    begin
        st_next = st_reg;
        st_next.expired = 1'b0;
        case (st_reg.state)
            SAT_TMR_IDLE:
            begin
                if (timerStart)
                begin
                    st_next.count = timerValue;
                    st_next.state = SAT_TMR_RUN;
                end
            end
            SAT_TMR_RUN:
            begin
                if (timerStart)
                begin
                    st_next.count = timerValue;
                end
                else if (st_reg.count <= TMR_W'(1))
                begin
                    st_next.count = '0;
                    st_next.expired = 1'b1;
                    st_next.state = SAT_TMR_IDLE;
                end
                else
                begin
                    st_next.count = st_reg.count - TMR_W'(1);
                end
            end
            default:
            begin
                st_next.state = SAT_TMR_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            st_reg.state <= SAT_TMR_IDLE;
            st_reg.count <= TMR_W'(SAT_TMR_RST);
            st_reg.expired <= 1'b0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign timerExpired = st_reg.expired;
    assign timerRunning = (st_reg.state == SAT_TMR_RUN);

endmodule

`default_nettype wire

// >>> src/sat_trigger_select.sv
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Four independent action sets per axis
// - Chosen factor fires its action at once
// - Other sets or axes may activate sets
// - One software code selects each factor
// - Twenty-four action types forwarded with fire
// - Code 1: compare register turns true
// - Code 2: internal timer expires
// - Codes 3-6: drive start, const in/out, end
// - Codes 7-9: split start, end, each pulse
// - Code A: pin m rises
// - Code C: pin m+4 low, pin m rises
// - Code D: pin m+4 high, pin m rises
// - Code E: pin m+4 low, pin m falls
// - Code F: pin m+4 high, pin m falls
// - Code 0: never self-triggers
// - Already-true compare waits for new true
// - Already-post-edge pin waits for fresh edge
// - Timer started by command or set
// - Repeat split fires per valid pulse
module sat_trigger_select
    import sat_pkg::*;
#(
    parameter int SETS = SAT_SETS,
    parameter int TMR_W = SAT_TMR_W
)
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [SETS-1:0] setEnable,
    input wire logic [SETS*SAT_CODE_W-1:0] factorCode,
    input wire logic [SETS*SAT_ACT_W-1:0] actionCode,
    input wire logic [SETS-1:0] multiPurposeCompareTrue,
    input wire logic [SETS-1:0] otherActivate,
    input wire logic timerStartCmd,
    input wire logic timerStartBySet,
    input wire logic [TMR_W-1:0] timerValue,
    input wire logic driveStart,
    input wire logic constSpeedStart,
    input wire logic constSpeedEnd,
    input wire logic driveEnd,
    input wire logic splitStart,
    input wire logic splitEnd,
    input wire logic splitPulseLevel,
    input wire logic splitValidHigh,
    input wire logic splitRepeat,
    input wire logic [SAT_PINS-1:0] generalIoPin,
    output logic [SETS-1:0] actionFire,
    output logic [SETS*SAT_ACT_W-1:0] actionSelect,
    output logic timerRunning
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [SAT_PINS-1:0] pinMeta;
        logic [SAT_PINS-1:0] pinSync;
        logic [SAT_PINS-1:0] pinPrev;
        logic [SAT_PIN_FILL-1:0] pinFill;
        logic [SETS-1:0] cmpPrev;
        logic [SETS-1:0] enPrev;
        logic splitPrev;
        logic splitSeen;
        logic [SETS-1:0] fire;
        logic [SETS*SAT_ACT_W-1:0] act;
    } sat_state_t;

    sat_state_t st_reg;
    sat_state_t st_next;
    logic timerExpired;
    logic [SETS-1:0] hit;
    logic splitValidEdge;
    logic pinLive;

    // ----------------------------------------------------------------
    // Internal timer
    // ----------------------------------------------------------------
    sat_timer #(
        .TMR_W(TMR_W)
    ) u_timer (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .timerStart(timerStartCmd | timerStartBySet),
        .timerValue(timerValue),
        .timerExpired(timerExpired),
        .timerRunning(timerRunning)
    );

    // ----------------------------------------------------------------
    // Split pulse and pin qualifiers
    // ----------------------------------------------------------------
    // Split pulse reaching its valid level, gated by repeat
    assign splitValidEdge = (splitPulseLevel == splitValidHigh)
        && (st_reg.splitPrev != splitValidHigh)
        && (splitRepeat || !st_reg.splitSeen);

    // No pin edge is trusted before three samples follow reset
    assign pinLive = st_reg.pinFill[SAT_PIN_FILL-1];

    // ----------------------------------------------------------------
    // Per-set factor decode
    // ----------------------------------------------------------------
    genvar m;
    generate
        for (m = 0; m < SETS; m++)
        begin : g_set
            logic [3:0] code;
            logic rise;
            logic fall;
            logic qual;
            logic cmpRise;
            logic armed;
            logic sel;
            assign code = factorCode[m*SAT_CODE_W +: SAT_CODE_W];
            // Edges come from the synced sample against its last; a pin
            // change reaches the fire flop on the third clock
            assign rise = pinLive && st_reg.pinSync[m]
                && !st_reg.pinPrev[m];
            assign fall = pinLive && !st_reg.pinSync[m]
                && st_reg.pinPrev[m];
            assign qual = st_reg.pinSync[m+4];
            assign cmpRise = multiPurposeCompareTrue[m]
                && !st_reg.cmpPrev[m];
            // Set must have been enabled already before the edge
            assign armed = setEnable[m] && st_reg.enPrev[m];

            // Factor selection
            always_comb
            begin
                sel = 1'b0;
                case (code)
                    SAT_NO_TRIGGER_CODE: sel = 1'b0;
                    SAT_CODE_CMP_TRUE: sel = cmpRise;
                    SAT_CODE_TIMER_UP: sel = timerExpired;
                    SAT_CODE_DRV_START: sel = driveStart;
                    SAT_CODE_CONST_START: sel = constSpeedStart;
                    SAT_CODE_CONST_END: sel = constSpeedEnd;
                    SAT_CODE_DRV_END: sel = driveEnd;
                    SAT_CODE_SPLIT_START: sel = splitStart;
                    SAT_CODE_SPLIT_END: sel = splitEnd;
                    SAT_CODE_SPLIT_PULSE: sel = splitValidEdge;
                    SAT_CODE_PIN_RISE: sel = rise;
                    SAT_CODE_PIN_FALL: sel = fall;
                    SAT_CODE_LOW_RISE: sel = rise && !qual;
                    SAT_CODE_HIGH_RISE: sel = rise && qual;
                    SAT_CODE_LOW_FALL: sel = fall && !qual;
                    SAT_CODE_HIGH_FALL: sel = fall && qual;
                    default: sel = 1'b0;
                endcase
            end

            // Each set decides alone; others may start it
            assign hit[m] = (armed && sel) || otherActivate[m];
        end
    endgenerate

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        st_next = st_reg;
        // Two-flop synchroniser, then last-sample store
        st_next.pinMeta = generalIoPin;
        st_next.pinSync = st_reg.pinMeta;
        st_next.pinPrev = st_reg.pinSync;
        // Edges stay blind until the pin pipeline holds real samples
        st_next.pinFill = {st_reg.pinFill[SAT_PIN_FILL-2:0], 1'b1};
        // Last compare, enable and split levels for the edge tests
        st_next.cmpPrev = multiPurposeCompareTrue;
        st_next.enPrev = setEnable;
        st_next.splitPrev = splitPulseLevel;
        // A pulse that passes the repeat gate in the same cycle as a start counts as the first
        if (splitValidEdge)
        begin
            st_next.splitSeen = 1'b1;
        end
        else if (splitStart)
        begin
            st_next.splitSeen = 1'b0;
        end
        // Fire pulse with the action that goes with it
        st_next.fire = hit;
        st_next.act = actionCode;
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            st_reg.pinMeta <= SAT_PIN_RST;
            st_reg.pinSync <= SAT_PIN_RST;
            st_reg.pinPrev <= SAT_PIN_RST;
            st_reg.pinFill <= SAT_FILL_RST;
            st_reg.cmpPrev <= SETS'(SAT_SET_RST);
            st_reg.enPrev <= SETS'(SAT_SET_RST);
            st_reg.splitPrev <= 1'b0;
            st_reg.splitSeen <= 1'b0;
            st_reg.fire <= SETS'(SAT_SET_RST);
            st_reg.act <= {SETS{SAT_ACT_RST}};
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // Fire and action leave straight from flip-flops
    assign actionFire = st_reg.fire;
    assign actionSelect = st_reg.act;

endmodule

`default_nettype wire

// >>> tb/sat_trigger_properties.sv
`timescale 1ns/1ps
`default_nettype none

module sat_trigger_properties
    import sat_pkg::*;
#(
    parameter int SETS = SAT_SETS,
    parameter int TMR_W = SAT_TMR_W
)
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [SETS-1:0] setEnable,
    input wire logic [SETS*SAT_CODE_W-1:0] factorCode,
    input wire logic [SETS*SAT_ACT_W-1:0] actionCode,
    input wire logic [SETS-1:0] multiPurposeCompareTrue,
    input wire logic [SETS-1:0] otherActivate,
    input wire logic timerStartCmd,
    input wire logic [TMR_W-1:0] timerValue,
    input wire logic driveStart,
    input wire logic driveEnd,
    input wire logic [SAT_PINS-1:0] generalIoPin,
    input wire logic [SETS-1:0] actionFire,
    input wire logic [SETS*SAT_ACT_W-1:0] actionSelect,
    input wire logic timerRunning
);

// ----------------------------------------------------------------
// Per-set trigger relations
// ----------------------------------------------------------------
default clocking @(posedge clk_sys);
endclocking
default disable iff (!nrst);

for (genvar m = 0; m < SETS; m++)
begin : g_set
    logic [3:0] code;
    logic [SETS-1:0] en;
    logic [SETS-1:0] cmp;
    // Code and level views of this set
    assign code = factorCode[m*4 +: 4];
    assign en = setEnable;
    assign cmp = multiPurposeCompareTrue;
    a_cmp_rise_fire: assert property (
        code == 4'h1 && en[m] && $past(en[m]) && $rose(cmp[m])
        |=> actionFire[m]) else $error("compare rise missed");
    a_cmp_held_quiet: assert property (
        code == 4'h1 && cmp[m] && $past(cmp[m]) && !otherActivate[m]
        |=> !actionFire[m]) else $error("held compare fired");
    a_other_fire: assert property (
        otherActivate[m] |=> actionFire[m]) else $error("no fire");
    a_nop_quiet: assert property (
        code == 4'h0 && !otherActivate[m] |=> !actionFire[m])
        else $error("idle code fired");
    a_off_quiet: assert property (
        !en[m] && !otherActivate[m] |=> !actionFire[m])
        else $error("disabled set fired");
    a_drive_fire: assert property (
        en[m] && $past(en[m]) && ((code == 4'h3 && driveStart) ||
        (code == 4'h6 && driveEnd)) |=> actionFire[m])
        else $error("drive event missed");
    a_pin_rise_fire: assert property (
        ($rose(generalIoPin[m]) && $past(nrst)) ##2
        (code == 4'ha && en[m] && $past(en[m])) |=> actionFire[m])
        else $error("pin rise missed");
end

// ----------------------------------------------------------------
// Shared relations
// ----------------------------------------------------------------
a_timer_run: assert property (
    timerStartCmd && timerValue > 3 |=> timerRunning)
    else $error("timer not running");
a_select_copy: assert property (
    $past(nrst) |-> actionSelect == $past(actionCode))
    else $error("action select wrong");
c_cmp_fire: cover property (actionFire[0]);
c_timer: cover property ($rose(timerRunning));
c_other: cover property (otherActivate[3] ##1 actionFire[3]);

endmodule

`default_nettype wire

// >>> tb/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb
    import sat_pkg::*;
;

logic clk_sys = 1'b0;
logic nrst;
logic [3:0] setEnable, mpc, otherActivate, actionFire;
logic [15:0] factorCode;
logic [19:0] actionCode, actionSelect;
logic [5:0] ev;
logic tStart, tSet, splitPulseLevel, splitRepeat, timerRunning;
logic splitValidHigh;
logic [31:0] timerValue;
logic [7:0] generalIoPin;
logic [31:0] cnt [4] = '{default: 32'h0};
logic [31:0] mark [4];
int fail_count = 0;
int compares = 0;

sat_trigger_select sat_trigger_select_i (.clk_sys(clk_sys), .nrst(nrst),
    .setEnable(setEnable), .factorCode(factorCode),
    .actionCode(actionCode), .multiPurposeCompareTrue(mpc),
    .otherActivate(otherActivate), .timerStartCmd(tStart),
    .timerStartBySet(tSet), .timerValue(timerValue),
    .driveStart(ev[0]), .constSpeedStart(ev[1]),
    .constSpeedEnd(ev[2]), .driveEnd(ev[3]), .splitStart(ev[4]),
    .splitEnd(ev[5]), .splitPulseLevel(splitPulseLevel),
    .splitValidHigh(splitValidHigh), .splitRepeat(splitRepeat),
    .generalIoPin(generalIoPin), .actionFire(actionFire),
    .actionSelect(actionSelect), .timerRunning(timerRunning));

// Clock and fire counters, counted away from the active edge
always #20 clk_sys = ~clk_sys;
always @(negedge clk_sys)
begin
    for (int i = 0; i < 4; i++)
        cnt[i] <= cnt[i] + 32'(actionFire[i] === 1'b1);
end

// ----------------------------------------------------------------
// Helpers
// ----------------------------------------------------------------
task automatic tick(int n);
    repeat (n)
    begin
        @(posedge clk_sys);
        #1;
    end
endtask

task automatic check(logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
        fail_count++;
        $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
endtask

task automatic arm(int m, logic [3:0] code);
    factorCode[m*4 +: 4] = code;
    setEnable[m] = 1'b1;
    tick(6);
    mark = cnt;
endtask

task automatic want(int m, logic [31:0] n);
    tick(12);
    check(cnt[m] - mark[m], n);
    mark = cnt;
endtask

task automatic test_done();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
        $display("Testbench passed");
    else
        $display("Testbench failed");
    $finish;
endtask

// ----------------------------------------------------------------
// Scenarios
// ----------------------------------------------------------------
task automatic t_cmp();
    mpc[0] = 1'b1;
    arm(0, SAT_CODE_CMP_TRUE);
    want(0, 0);
    mpc[0] = 1'b0;
    tick(1);
    mpc[0] = 1'b1;
    want(0, 1);
    setEnable[0] = 1'b0;
    mpc[0] = 1'b0;
    tick(1);
    mpc[0] = 1'b1;
    want(0, 0);
    mpc[0] = 1'b0;
endtask

task automatic t_drive();
    for (int c = 3; c <= 8; c++)
    begin
        arm(1, 4'(c));
        ev = ~(6'h01 << (c - 3));
        tick(1);
        ev = 6'h00;
        want(1, 0);
        ev = 6'h01 << (c - 3);
        tick(1);
        ev = 6'h00;
        want(1, 1);
    end
endtask

task automatic t_split();
    for (int r = 0; r < 2; r++)
    begin
        splitValidHigh = r[0];
        splitPulseLevel = !r[0];
        arm(1, SAT_CODE_SPLIT_PULSE);
        splitRepeat = r[0];
        ev = 6'h10;
        tick(1);
        ev = 6'h00;
        repeat (2)
        begin
            splitPulseLevel = r[0];
            tick(2);
            splitPulseLevel = !r[0];
            tick(2);
        end
        want(1, r ? 2 : 1);
    end
endtask

task automatic t_pins();
    logic rise;
    generalIoPin = 8'h04;
    tick(4);
    arm(2, SAT_CODE_PIN_RISE);
    want(2, 0);
    for (int k = 0; k < 6; k++)
    begin
        rise = (k == 0 || k == 2 || k == 3);
        generalIoPin[2] = !rise;
        generalIoPin[6] = k[0];
        arm(2, 4'ha + 4'(k));
        generalIoPin[2] = rise;
        want(2, 1);
        generalIoPin[2] = !rise;
        generalIoPin[6] = !k[0];
        want(2, 0);
        generalIoPin[2] = rise;
        want(2, k < 2);
    end
endtask

task automatic t_nop();
    arm(3, SAT_NO_TRIGGER_CODE);
    mpc[3] = 1'b1;
    ev = 6'h3f;
    generalIoPin[3] = 1'b1;
    tick(1);
    ev = 6'h00;
    want(3, 0);
    setEnable[3] = 1'b0;
    otherActivate[3] = 1'b1;
    tick(1);
    otherActivate[3] = 1'b0;
    want(3, 1);
    mpc[3] = 1'b0;
endtask

task automatic t_timer();
    timerValue = 32'h5;
    arm(3, SAT_CODE_TIMER_UP);
    tStart = 1'b1;
    tick(1);
    tStart = 1'b0;
    check(32'(timerRunning), 1);
    want(3, 1);
    tSet = 1'b1;
    tick(1);
    tSet = 1'b0;
    want(3, 1);
endtask

// ----------------------------------------------------------------
// Main sequence and watchdog
// ----------------------------------------------------------------
initial
begin
    {nrst, setEnable, mpc, otherActivate, factorCode, ev} = '0;
    {tStart, tSet, splitPulseLevel, splitRepeat, splitValidHigh} = '0;
    {timerValue, generalIoPin} = '0;
    mark = cnt;
    actionCode = {5'h0a, 5'h17, 5'h09, 5'h01};
    tick(2);
    nrst = 1'b1;
    tick(4);
    check(32'(actionSelect), 32'(actionCode));
    t_cmp();
    t_drive();
    t_split();
    t_pins();
    t_nop();
    t_timer();
    actionCode = {5'h0c, 5'h02, 5'h10, 5'h05};
    tick(2);
    check(32'(actionSelect), 32'(actionCode));
    test_done();
end

// Runs take well under 1000 cycles; this allows five times that
initial
begin
    #200000;
    fail_count++;
    test_done();
end

endmodule

bind sat_trigger_select sat_trigger_properties #(.SETS(SETS),
    .TMR_W(TMR_W)) sat_trigger_properties_i (.clk_sys(clk_sys),
    .nrst(nrst), .setEnable(setEnable), .factorCode(factorCode),
    .actionCode(actionCode), .otherActivate(otherActivate),
    .multiPurposeCompareTrue(multiPurposeCompareTrue),
    .timerStartCmd(timerStartCmd), .timerValue(timerValue),
    .driveStart(driveStart), .driveEnd(driveEnd),
    .generalIoPin(generalIoPin), .actionFire(actionFire),
    .actionSelect(actionSelect), .timerRunning(timerRunning));

`default_nettype wire
